// ==== ctf_pkg.sv ====
// shared constants and types for the transmit handler and acceptance filter
package ctf_pkg;

  // buffer area layout defaults and phase segment 2 field width
  localparam int NBUF_DEF = 8;
  localparam int NDED_DEF = 4;
  localparam int SEG2_W   = 7;

  // transmit queue mode
  localparam logic TQM_FIFO  = 1'b0;
  localparam logic TQM_QUEUE = 1'b1;

  // filter type encodings
  localparam logic [1:0] FT_RANGE   = 2'h0;
  localparam logic [1:0] FT_DUAL    = 2'h1;
  localparam logic [1:0] FT_CLASSIC = 2'h2;

  // filter element configuration encodings
  localparam logic [2:0] FEC_FIFO0   = 3'h1;
  localparam logic [2:0] FEC_FIFO1   = 3'h2;
  localparam logic [2:0] FEC_PRIO    = 3'h4;
  localparam logic [2:0] FEC_PRIO_F0 = 3'h5;
  localparam logic [2:0] FEC_PRIO_F1 = 3'h6;

  // global non-matching frame settings
  localparam logic [1:0] ANF_FIFO0 = 2'h0;
  localparam logic [1:0] ANF_FIFO1 = 2'h1;

  // identifier layout: standard id sits in the top 11 bits
  localparam int ID_W      = 29;
  localparam int STD_ID_W  = 11;
  localparam int STD_LSB   = 18;
  localparam logic [ID_W-1:0] STD_MASK = 29'h000007FF;
  localparam logic [ID_W-1:0] EXT_MASK = 29'h1FFFFFFF;

  // recessive and dominant bus levels
  localparam logic BUS_DOM = 1'b0;
  localparam logic BUS_REC = 1'b1;

  typedef struct packed {
    logic            xtd;
    logic [ID_W-1:0] id;
  } ctf_txhdr_t;

  typedef struct packed {
    logic [1:0]      ftype;
    logic [2:0]      fec;
    logic [ID_W-1:0] id_first;
    logic [ID_W-1:0] id_second;
  } ctf_filt_t;

  // events from the protocol controller, same clock
  typedef struct packed {
    logic sample_pt;
    logic ifs3;
    logic bus_idle;
    logic tx_ok;
    logic arb_lost;
    logic bus_err;
  } ctf_pc_evt_t;

  typedef enum logic [0:0] {
    CTF_TX_IDLE   = 1'b0,
    CTF_TX_ACTIVE = 1'b1
  } ctf_tx_state_t;

endpackage

// ==== ctf_top.sv ====
// transmit message handler with output pipeline and receive acceptance filter
`timescale 1ns/1ns

// How it works
// - pending frame starts when the third intermission bit is sampled dominant, taken as SOF.
// - phase segment 2 length equals the field value plus one time quantum.
// - phase segment 2 field is wide enough to cover at least 2..8 tq.
// - frame started from intermission drives its first identifier bit from the buffer element.
// - with no-retransmit control set, failed frames are not retried.
// - no-retransmit failure clears pending and sets cancel-finished of the transmitted buffer only.
// - three-position output pipeline refreshed by scans; position 1 is on the bus.
// - higher-priority request is inserted ahead; a failed entry may be displaced, rescanned later.
// - queue mode 0 lets dedicated buffers and a FIFO share the buffer area.
// - add request sets pending; completion raises complete flag and occurred bit.
// - FIFO-empty flag rises when a FIFO transmission completes and the FIFO drains.
// - filter configs 100, 101, 110 are high priority and raise the priority flag.
// - global setting 00 or 01 accepts non-matching frames into a receive FIFO.
// - frames accepted only through the global setting never raise the priority flag.
// - filter configs 001 and 010 store into receive FIFO 0 and FIFO 1.
// - filter type 10 is classic: first id is filter, second is mask, mask 0 ignores.
module ctf_top #(
  parameter int NBUF = ctf_pkg::NBUF_DEF,
  parameter int NDED = ctf_pkg::NDED_DEF
) (
  // clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        nrst,
  // configuration
  input  wire logic [ctf_pkg::SEG2_W-1:0]  nominal_phase_seg2_field,
  input  wire logic                        disable_auto_retx_ctl,
  input  wire logic                        tx_queue_mode_sel,
  input  wire logic [1:0]                  accept_nonmatch_standard,
  input  wire logic [1:0]                  accept_nonmatch_extended,
  // transmit buffer area
  input  wire logic [NBUF-1:0]             tx_add_request_reg,
  input  wire ctf_pkg::ctf_txhdr_t         tx_buf_hdr [NBUF],
  output logic [NBUF-1:0]                  tx_request_pending_bit,
  output logic [NBUF-1:0]                  tx_cancel_finished_bit,
  output logic [NBUF-1:0]                  tx_occurred_reg,
  // flags, write one to clear
  input  wire logic                        tx_complete_clr,
  input  wire logic                        tx_fifo_empty_clr,
  input  wire logic                        high_priority_msg_clr,
  output logic                             tx_complete_flag,
  output logic                             tx_fifo_empty_flag,
  output logic                             high_priority_msg_flag,
  // protocol controller
  input  wire ctf_pkg::ctf_pc_evt_t        pc_evt,
  input  wire logic                        can_rx,
  output logic                             tx_start,
  output ctf_pkg::ctf_txhdr_t              tx_hdr_ff,
  output logic [$clog2(NBUF)-1:0]          tx_buf_ff,
  output logic                             tx_bit_ff,
  output logic [ctf_pkg::SEG2_W:0]         phase_seg2_tq_ff,
  // acceptance filter
  input  wire logic                        std_filt_en,
  input  wire ctf_pkg::ctf_filt_t          std_filt,
  input  wire logic                        ext_filt_en,
  input  wire ctf_pkg::ctf_filt_t          ext_filt,
  input  wire logic                        rx_done,
  input  wire ctf_pkg::ctf_txhdr_t         rx_hdr,
  output logic                             rx_accept_ff,
  output logic                             rx_fifo1_ff
);
  import ctf_pkg::*;

  localparam int IW = $clog2(NBUF);

  initial begin
    if (NBUF < 2 || NBUF > 32 || NDED < 1 || NDED >= NBUF) begin
      $error("ctf_top: NBUF must be 2..32 and NDED 1..NBUF-1");
    end
    if (SEG2_W < 3) begin
      $error("ctf_top: phase segment 2 field too narrow");
    end
  end

  // lower key wins: base id, then standard before extended, then extension bits
  function automatic logic [ID_W:0] prio_key(input ctf_txhdr_t h);
    prio_key = {h.id[ID_W-1:STD_LSB], h.xtd, h.xtd ? h.id[STD_LSB-1:0] : 18'h00000};
  endfunction

  function automatic logic better(input logic [IW-1:0] a, input logic [IW-1:0] b);
    logic [ID_W:0] ka;
    logic [ID_W:0] kb;
    ka = prio_key(tx_buf_hdr[a]);
    kb = prio_key(tx_buf_hdr[b]);
    better = (ka < kb) || (ka == kb && a < b);
  endfunction

  function automatic logic filt_hit(input ctf_filt_t f, input logic [ID_W-1:0] id,
                                    input logic [ID_W-1:0] wm);
    logic [ID_W-1:0] f1;
    logic [ID_W-1:0] f2;
    f1 = f.id_first & wm;
    f2 = f.id_second & wm;
    unique case (f.ftype)
      FT_RANGE:   filt_hit = (id >= f1) && (id <= f2);
      FT_DUAL:    filt_hit = (id == f1) || (id == f2);
      FT_CLASSIC: filt_hit = ((id ^ f1) & f2) == '0;
      default:    filt_hit = 1'b0;
    endcase
  endfunction

  // rx pin synchroniser
  logic rx_meta_ff;
  logic rx_sync_ff;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_meta_ff <= BUS_REC;
      rx_sync_ff <= BUS_REC;
    end else begin
      rx_meta_ff <= can_rx;
      rx_sync_ff <= rx_meta_ff;
    end
  end

  // transmit handler state
  ctf_tx_state_t   state_ff;
  ctf_tx_state_t   nxt_state;
  logic [NBUF-1:0] nxt_pend;
  logic [NBUF-1:0] nxt_cf;
  logic [NBUF-1:0] nxt_occ;
  logic            pv_ff   [3];
  logic [IW-1:0]   pidx_ff [3];
  logic            nxt_pv  [3];
  logic [IW-1:0]   nxt_pidx[3];
  logic [IW-1:0]   scan_ff;
  logic [IW-1:0]   nxt_scan;
  logic            best_v_ff;
  logic            nxt_best_v;
  logic [IW-1:0]   best_ff;
  logic [IW-1:0]   nxt_best;
  logic [IW-1:0]   fget_ff;
  logic [IW-1:0]   nxt_fget;
  logic            nxt_tc;
  logic            nxt_tfe;
  ctf_txhdr_t      nxt_hdr;
  logic [IW-1:0]   nxt_buf;
  logic            nxt_bit;

  function automatic logic in_pipe(input logic v[3], input logic [IW-1:0] p[3], input logic [IW-1:0] i);
    in_pipe = (v[0] && p[0] == i) || (v[1] && p[1] == i) || (v[2] && p[2] == i);
  endfunction

  // only the oldest FIFO element may enter the pipeline in FIFO mode
  function automatic logic eligible(input logic [IW-1:0] i, input logic [NBUF-1:0] pend,
                                    input logic [IW-1:0] fget);
    eligible = pend[i] && (tx_queue_mode_sel == TQM_QUEUE || 32'(i) < NDED || i == fget);
  endfunction

  always_comb begin
    logic          done;
    logic          fail;
    logic          rm;
    logic          cv;
    logic [IW-1:0] ci;
    int            ins;
    int            lo;
    logic          pv  [3];
    logic [IW-1:0] pidx[3];
    done = 1'b0;
    fail = 1'b0;
    rm   = 1'b0;
    cv   = 1'b0;
    ci   = '0;
    ins  = 3;
    lo   = 0;
    pv   = pv_ff;
    pidx = pidx_ff;
    nxt_state  = state_ff;
    nxt_pend   = tx_request_pending_bit | tx_add_request_reg;
    nxt_cf     = tx_cancel_finished_bit & ~tx_add_request_reg;
    nxt_occ    = tx_occurred_reg & ~tx_add_request_reg;
    nxt_fget   = fget_ff;
    nxt_tc     = tx_complete_flag & ~tx_complete_clr;
    nxt_tfe    = tx_fifo_empty_flag & ~tx_fifo_empty_clr;
    nxt_hdr    = tx_hdr_ff;
    nxt_buf    = tx_buf_ff;
    nxt_bit    = tx_bit_ff;
    nxt_scan   = (32'(scan_ff) == NBUF - 1) ? '0 : scan_ff + IW'(1);
    nxt_best_v = best_v_ff;
    nxt_best   = best_ff;
    tx_start   = 1'b0;
    unique case (state_ff)
      CTF_TX_IDLE: begin
        if (pv[0] && pc_evt.ifs3 && pc_evt.sample_pt && rx_sync_ff == BUS_DOM) begin
          tx_start  = 1'b1;
          nxt_bit   = tx_buf_hdr[pidx[0]].id[ID_W-1];
        end else if (pv[0] && pc_evt.bus_idle) begin
          tx_start  = 1'b1;
          nxt_bit   = BUS_DOM;
        end
        if (tx_start) begin
          nxt_state = CTF_TX_ACTIVE;
          nxt_hdr   = tx_buf_hdr[pidx[0]];
          nxt_buf   = pidx[0];
        end
      end
      CTF_TX_ACTIVE: begin
        done = pc_evt.tx_ok;
        fail = !pc_evt.tx_ok && (pc_evt.arb_lost || pc_evt.bus_err);
        if (done || fail) begin
          nxt_state = CTF_TX_IDLE;
          nxt_bit   = BUS_REC;
        end
      end
    endcase
    if (done) begin
      nxt_pend[tx_buf_ff] = tx_add_request_reg[tx_buf_ff];
      nxt_occ[tx_buf_ff]  = 1'b1;
      nxt_tc              = 1'b1;
      rm                  = 1'b1;
    end else if (fail && disable_auto_retx_ctl) begin
      nxt_pend[tx_buf_ff] = tx_add_request_reg[tx_buf_ff];
      nxt_cf[tx_buf_ff]   = 1'b1;
      rm                  = 1'b1;
    end
    if (rm && 32'(tx_buf_ff) >= NDED && tx_buf_ff == fget_ff) begin
      nxt_fget = (32'(fget_ff) == NBUF - 1) ? IW'(NDED) : fget_ff + IW'(1);
    end
    if (done && 32'(tx_buf_ff) >= NDED && (nxt_pend >> NDED) == '0) begin
      nxt_tfe = 1'b1;
    end
    if (rm) begin
      pv[0]   = pv[1];
      pidx[0] = pidx[1];
      pv[1]   = pv[2];
      pidx[1] = pidx[2];
      pv[2]   = 1'b0;
    end
    // scan step: keep the best eligible buffer not yet in the pipeline
    if (eligible(scan_ff, tx_request_pending_bit, fget_ff) && !in_pipe(pv_ff, pidx_ff, scan_ff) &&
        (!best_v_ff || better(scan_ff, best_ff))) begin
      nxt_best_v = 1'b1;
      nxt_best   = scan_ff;
    end
    if (32'(scan_ff) == NBUF - 1) begin
      cv         = nxt_best_v && eligible(nxt_best, nxt_pend, nxt_fget) && !in_pipe(pv, pidx, nxt_best);
      ci         = nxt_best;
      nxt_best_v = 1'b0;
    end
    // position 1 is locked while its frame is on the bus
    lo = (nxt_state == CTF_TX_ACTIVE) ? 1 : 0;
    if (cv) begin
      for (int i = 2; i >= 0; i--) begin
        if (i >= lo && (!pv[i] || better(ci, pidx[i]))) begin
          ins = i;
        end
      end
    end
    for (int i = 0; i < 3; i++) begin
      if (i < ins) begin
        nxt_pv[i]   = pv[i];
        nxt_pidx[i] = pidx[i];
      end else if (i == ins) begin
        nxt_pv[i]   = 1'b1;
        nxt_pidx[i] = ci;
      end else begin
        nxt_pv[i]   = pv[i-1];
        nxt_pidx[i] = pidx[i-1];
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff               <= CTF_TX_IDLE;
      tx_request_pending_bit <= '0;
      tx_cancel_finished_bit <= '0;
      tx_occurred_reg        <= '0;
      pv_ff                  <= '{1'b0, 1'b0, 1'b0};
      pidx_ff                <= '{IW'(0), IW'(0), IW'(0)};
      scan_ff                <= '0;
      best_v_ff              <= 1'b0;
      best_ff                <= '0;
      fget_ff                <= IW'(NDED);
      tx_complete_flag       <= 1'b0;
      tx_fifo_empty_flag     <= 1'b0;
      tx_hdr_ff              <= '0;
      tx_buf_ff              <= '0;
      tx_bit_ff              <= BUS_REC;
    end else begin
      state_ff               <= nxt_state;
      tx_request_pending_bit <= nxt_pend;
      tx_cancel_finished_bit <= nxt_cf;
      tx_occurred_reg        <= nxt_occ;
      pv_ff                  <= nxt_pv;
      pidx_ff                <= nxt_pidx;
      scan_ff                <= nxt_scan;
      best_v_ff              <= nxt_best_v;
      best_ff                <= nxt_best;
      fget_ff                <= nxt_fget;
      tx_complete_flag       <= nxt_tc;
      tx_fifo_empty_flag     <= nxt_tfe;
      tx_hdr_ff              <= nxt_hdr;
      tx_buf_ff              <= nxt_buf;
      tx_bit_ff              <= nxt_bit;
    end
  end

  // bit timing: phase segment 2 in time quanta
  logic [SEG2_W:0] nxt_seg2;
  always_comb begin
    nxt_seg2 = {1'b0, nominal_phase_seg2_field} + (SEG2_W+1)'(1);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      phase_seg2_tq_ff <= (SEG2_W+1)'(1);
    end else begin
      phase_seg2_tq_ff <= nxt_seg2;
    end
  end

  // acceptance filter
  logic nxt_acc;
  logic nxt_f1;
  logic nxt_hpm;
  always_comb begin
    logic            en;
    logic            hit;
    logic [2:0]      fec;
    logic [1:0]      anf;
    logic [ID_W-1:0] id;
    en  = rx_hdr.xtd ? ext_filt_en : std_filt_en;
    fec = rx_hdr.xtd ? ext_filt.fec : std_filt.fec;
    anf = rx_hdr.xtd ? accept_nonmatch_extended : accept_nonmatch_standard;
    id  = rx_hdr.xtd ? rx_hdr.id : {18'h00000, rx_hdr.id[ID_W-1:STD_LSB]};
    hit = en && (rx_hdr.xtd ? filt_hit(ext_filt, id, EXT_MASK) : filt_hit(std_filt, id, STD_MASK));
    nxt_acc = 1'b0;
    nxt_f1  = rx_fifo1_ff;
    nxt_hpm = high_priority_msg_flag & ~high_priority_msg_clr;
    if (rx_done) begin
      if (hit && fec != '0) begin
        unique case (fec)
          FEC_FIFO0, FEC_FIFO1: begin
            nxt_acc = 1'b1;
            nxt_f1  = (fec == FEC_FIFO1);
          end
          FEC_PRIO, FEC_PRIO_F0, FEC_PRIO_F1: begin
            nxt_acc = 1'b1;
            nxt_f1  = (fec == FEC_PRIO_F1);
            nxt_hpm = 1'b1;
          end
          default: nxt_acc = 1'b0;
        endcase
      end else if (!hit && (anf == ANF_FIFO0 || anf == ANF_FIFO1)) begin
        nxt_acc = 1'b1;
        nxt_f1  = (anf == ANF_FIFO1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_accept_ff           <= 1'b0;
      rx_fifo1_ff            <= 1'b0;
      high_priority_msg_flag <= 1'b0;
    end else begin
      rx_accept_ff           <= nxt_acc;
      rx_fifo1_ff            <= nxt_f1;
      high_priority_msg_flag <= nxt_hpm;
    end
  end

endmodule // ctf_top

// ==== ctf_assertions.sv ====
// assertion checker for the transmit handler and acceptance filter
`timescale 1ns/1ns
module ctf_assertions #(
  parameter int NBUF = ctf_pkg::NBUF_DEF
) (
  // clock and reset
  input wire logic                       core_clk,
  input wire logic                       nrst,
  // configuration
  input wire logic [ctf_pkg::SEG2_W-1:0] nominal_phase_seg2_field,
  input wire logic                       disable_auto_retx_ctl,
  input wire logic [1:0]                 accept_nonmatch_extended,
  // transmit side
  input wire logic [NBUF-1:0]            tx_add_request_reg,
  input wire logic [NBUF-1:0]            tx_request_pending_bit,
  input wire logic [NBUF-1:0]            tx_cancel_finished_bit,
  input wire logic [NBUF-1:0]            tx_occurred_reg,
  input wire logic                       tx_complete_flag,
  input wire ctf_pkg::ctf_pc_evt_t       pc_evt,
  input wire logic                       tx_start,
  input wire ctf_pkg::ctf_txhdr_t        tx_hdr_ff,
  input wire logic [$clog2(NBUF)-1:0]    tx_buf_ff,
  input wire logic                       tx_bit_ff,
  input wire logic [ctf_pkg::SEG2_W:0]   phase_seg2_tq_ff,
  // receive side
  input wire logic                       ext_filt_en,
  input wire logic                       rx_done,
  input wire ctf_pkg::ctf_txhdr_t        rx_hdr,
  input wire logic                       rx_accept_ff,
  input wire logic                       rx_fifo1_ff,
  input wire logic                       high_priority_msg_flag
);
  import ctf_pkg::*;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  seg2_len_a: assert property (
    $past(nrst) |-> phase_seg2_tq_ff == {1'b0, $past(nominal_phase_seg2_field)} + 8'h01)
    else $error("seg2 length not field plus one");
  start_cause_a: assert property (
    tx_start |-> pc_evt.bus_idle || (pc_evt.ifs3 && pc_evt.sample_pt))
    else $error("frame start without cause");
  first_bit_a: assert property (
    tx_start && !pc_evt.bus_idle |=> tx_bit_ff == tx_hdr_ff.id[ID_W-1])
    else $error("first id bit differs from buffer");
  idle_sof_a: assert property (
    tx_start && pc_evt.bus_idle && !pc_evt.ifs3 |=> tx_bit_ff == BUS_DOM)
    else $error("start of frame not dominant");
  drop_fail_a: assert property (
    disable_auto_retx_ctl && (pc_evt.arb_lost || pc_evt.bus_err) && tx_request_pending_bit[tx_buf_ff]
    && tx_add_request_reg == '0 |=> !tx_request_pending_bit[$past(tx_buf_ff)]
    && tx_cancel_finished_bit == ($past(tx_cancel_finished_bit) | ({{(NBUF-1){1'b0}}, 1'b1} << $past(tx_buf_ff))))
    else $error("no-retransmit failure bookkeeping wrong");
  keep_retx_a: assert property (
    !disable_auto_retx_ctl && (pc_evt.arb_lost || pc_evt.bus_err) && tx_request_pending_bit[tx_buf_ff]
    |=> tx_request_pending_bit[$past(tx_buf_ff)] && !tx_cancel_finished_bit[$past(tx_buf_ff)])
    else $error("failed frame dropped in retransmit mode");
  done_mark_a: assert property (
    pc_evt.tx_ok && tx_request_pending_bit[tx_buf_ff] && tx_add_request_reg == '0
    |=> tx_occurred_reg[$past(tx_buf_ff)] && !tx_request_pending_bit[$past(tx_buf_ff)] && tx_complete_flag)
    else $error("completion not recorded");
  add_pend_a: assert property (
    |tx_add_request_reg |=> (tx_request_pending_bit & $past(tx_add_request_reg)) == $past(tx_add_request_reg))
    else $error("add request did not set pending");
  anf_ext_a: assert property (
    rx_done && rx_hdr.xtd && !ext_filt_en && !accept_nonmatch_extended[1]
    |=> rx_accept_ff && rx_fifo1_ff == $past(accept_nonmatch_extended[0]) && !$rose(high_priority_msg_flag))
    else $error("non-matching extended frame wrong");
endmodule  // ctf_assertions

bind ctf_top ctf_assertions #(.NBUF(NBUF)) i_ctf_assertions (.core_clk, .nrst, .nominal_phase_seg2_field,
  .disable_auto_retx_ctl, .accept_nonmatch_extended, .tx_add_request_reg, .tx_request_pending_bit,
  .tx_cancel_finished_bit, .tx_occurred_reg, .tx_complete_flag, .pc_evt, .tx_start, .tx_hdr_ff, .tx_buf_ff,
  .tx_bit_ff, .phase_seg2_tq_ff, .ext_filt_en, .rx_done, .rx_hdr, .rx_accept_ff, .rx_fifo1_ff,
  .high_priority_msg_flag);

// ==== ctf_bus_node.sv ====
// behavioural model of the other nodes on the shared bus
`timescale 1ns/1ns
module ctf_bus_node (
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            nrst,
  // bench control
  input  wire logic            bus_free,
  input  wire logic            dom_ifs3,
  input  wire logic [1:0]      res_sel,
  // device side
  input  wire logic            tx_start,
  output ctf_pkg::ctf_pc_evt_t pc_evt,
  output logic                 can_rx
);
  import ctf_pkg::*;
  logic [1:0] dom_cnt_ff;
  logic [1:0] nxt_dom_cnt;
  logic [3:0] run_cnt_ff;
  logic [3:0] nxt_run_cnt;
  logic [1:0] res_ff;
  logic [1:0] nxt_res;
  // outcome of a frame is fixed at its start
  always_comb begin
    nxt_dom_cnt = (dom_cnt_ff != 2'h0) ? dom_cnt_ff - 2'h1 : (dom_ifs3 ? 2'h3 : 2'h0);
    nxt_run_cnt = (run_cnt_ff != 4'h0) ? run_cnt_ff - 4'h1 : (tx_start ? 4'hF : 4'h0);
    nxt_res = tx_start ? res_sel : res_ff;
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dom_cnt_ff <= 2'h0;
      run_cnt_ff <= 4'h0;
      res_ff <= 2'h0;
    end else begin
      dom_cnt_ff <= nxt_dom_cnt;
      run_cnt_ff <= nxt_run_cnt;
      res_ff <= nxt_res;
    end
  end
  // pull-up keeps the bus recessive unless another node drives it
  assign can_rx = (dom_cnt_ff != 2'h0) ? BUS_DOM : BUS_REC;
  always_comb begin
    pc_evt = '0;
    pc_evt.sample_pt = (dom_cnt_ff == 2'h1);
    pc_evt.ifs3 = (dom_cnt_ff == 2'h1);
    pc_evt.bus_idle = bus_free && dom_cnt_ff == 2'h0 && run_cnt_ff == 4'h0;
    pc_evt.tx_ok = run_cnt_ff == 4'h1 && res_ff == 2'h0;
    pc_evt.arb_lost = run_cnt_ff == 4'h1 && res_ff == 2'h1;
    pc_evt.bus_err = run_cnt_ff == 4'h1 && res_ff == 2'h2;
  end
endmodule  // ctf_bus_node

// ==== tb_top.sv ====
// self-checking bench for the transmit handler and acceptance filter
`timescale 1ns/1ns
module tb_top;
  import ctf_pkg::*;
  localparam int NB = 8;
  typedef struct packed {
    logic        xtd;
    logic [2:0]  fec;
    logic [10:0] fid;
    logic [10:0] fmsk;
    logic [10:0] rid;
    logic [1:0]  anf;
    logic        acc;
    logic        fifo1;
    logic        hpm;
  } ctf_row_t;
  ctf_row_t rows [12] = '{
    '{1'b0, 3'h1, 11'h123, 11'h7FF, 11'h123, 2'h2, 1'b1, 1'b0, 1'b0},
    '{1'b0, 3'h2, 11'h123, 11'h7FF, 11'h123, 2'h2, 1'b1, 1'b1, 1'b0},
    '{1'b0, 3'h4, 11'h123, 11'h7FF, 11'h123, 2'h2, 1'b1, 1'b0, 1'b1},
    '{1'b0, 3'h5, 11'h123, 11'h7FF, 11'h123, 2'h2, 1'b1, 1'b0, 1'b1},
    '{1'b0, 3'h6, 11'h123, 11'h7FF, 11'h123, 2'h2, 1'b1, 1'b1, 1'b1},
    '{1'b0, 3'h1, 11'h120, 11'h7F0, 11'h12F, 2'h2, 1'b1, 1'b0, 1'b0},
    '{1'b0, 3'h1, 11'h120, 11'h7FF, 11'h12F, 2'h2, 1'b0, 1'b0, 1'b0},
    '{1'b0, 3'h1, 11'h120, 11'h7FF, 11'h12F, 2'h0, 1'b1, 1'b0, 1'b0},
    '{1'b0, 3'h1, 11'h120, 11'h7FF, 11'h12F, 2'h1, 1'b1, 1'b1, 1'b0},
    '{1'b0, 3'h4, 11'h120, 11'h7FF, 11'h12F, 2'h1, 1'b1, 1'b1, 1'b0},
    '{1'b0, 3'h4, 11'h123, 11'h7FF, 11'h123, 2'h0, 1'b1, 1'b0, 1'b1},
    '{1'b1, 3'h4, 11'h123, 11'h7FF, 11'h123, 2'h0, 1'b1, 1'b0, 1'b0}};
  logic              core_clk = 1'b0;
  logic              nrst = 1'b0;
  logic [SEG2_W-1:0] nominal_phase_seg2_field = '0;
  logic              disable_auto_retx_ctl = 1'b0;
  logic [1:0]        anf = 2'h2;
  logic [NB-1:0]     tx_add_request_reg = '0;
  ctf_txhdr_t        tx_buf_hdr [NB];
  logic              flag_clr = 1'b0;
  ctf_filt_t         std_filt = '0;
  logic              rx_done = 1'b0;
  ctf_txhdr_t        rx_hdr = '0;
  logic              tqm = TQM_FIFO;
  logic              bus_free = 1'b0;
  logic              dom_ifs3 = 1'b0;
  logic [1:0]        res_sel = 2'h0;
  ctf_pc_evt_t       pc_evt;
  logic              can_rx, tx_start, tx_bit_ff, tcf, tfe, hpm, rx_accept_ff, rx_fifo1_ff;
  logic [NB-1:0]     pend, cfin, occ;
  logic [2:0]        tx_buf_ff;
  logic [SEG2_W:0]   phase_seg2_tq_ff;
  logic [2:0]        done_q [$], fq [$];
  int                num_errors = 0, num_checks = 0, cycles = 0;
  ctf_top #(.NBUF(NB), .NDED(4)) i_ctf_top (.core_clk, .nrst, .nominal_phase_seg2_field, .disable_auto_retx_ctl,
    .tx_queue_mode_sel(tqm), .accept_nonmatch_standard(anf), .accept_nonmatch_extended(anf),
    .tx_add_request_reg, .tx_buf_hdr, .tx_request_pending_bit(pend), .tx_cancel_finished_bit(cfin),
    .tx_occurred_reg(occ), .tx_complete_clr(flag_clr), .tx_fifo_empty_clr(flag_clr),
    .high_priority_msg_clr(flag_clr), .tx_complete_flag(tcf), .tx_fifo_empty_flag(tfe),
    .high_priority_msg_flag(hpm), .pc_evt, .can_rx, .tx_start, .tx_hdr_ff(), .tx_buf_ff, .tx_bit_ff,
    .phase_seg2_tq_ff, .std_filt_en(1'b1), .std_filt, .ext_filt_en(1'b0), .ext_filt('0), .rx_done, .rx_hdr,
    .rx_accept_ff, .rx_fifo1_ff);
  ctf_bus_node i_ctf_bus_node (.core_clk, .nrst, .bus_free, .dom_ifs3, .res_sel, .tx_start, .pc_evt, .can_rx);
  always #4 core_clk = ~core_clk;
  always @(negedge core_clk) if (nrst && pc_evt.tx_ok === 1'b1) done_q.push_back(tx_buf_ff);
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic req(input logic [NB-1:0] m);
    @(posedge core_clk) tx_add_request_reg <= m;
    @(posedge core_clk) tx_add_request_reg <= '0;
  endtask
  task automatic wait_start();
    @(negedge core_clk);
    for (int k = 0; k < 100 && tx_start !== 1'b1; k++) @(negedge core_clk);
    chk("tx_start", 1, tx_start);
  endtask
  task automatic wait_done(input int n);
    for (int k = 0; k < 900 && done_q.size() < n; k++) @(negedge core_clk);
    chk("completions", n, done_q.size());
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic rx(input ctf_row_t r);
    @(posedge core_clk) begin
      flag_clr <= 1'b1;
      anf <= r.anf;
      std_filt <= '{FT_CLASSIC, r.fec, {18'h00000, r.fid}, {18'h00000, r.fmsk}};
    end
    @(posedge core_clk) begin
      flag_clr <= 1'b0;
      rx_done <= 1'b1;
      rx_hdr.xtd <= r.xtd;
      rx_hdr.id <= r.xtd ? {18'h00000, r.rid} : {r.rid, 18'h00000};
    end
    @(posedge core_clk) rx_done <= 1'b0;
    #1;
    chk("accept", r.acc, rx_accept_ff);
    if (r.acc) chk("fifo1", r.fifo1, rx_fifo1_ff);
    chk("hpm flag", r.hpm, hpm);
  endtask

  initial begin
    foreach (tx_buf_hdr[b]) tx_buf_hdr[b] = '{1'b0, {11'h700, 18'h00000}};
    tx_buf_hdr[0].id = {11'h010, 18'h00000};
    tx_buf_hdr[1].id = {11'h400, 18'h00000};
    tx_buf_hdr[2].id = {11'h300, 18'h00000};
    tx_buf_hdr[3].id = {11'h200, 18'h00000};
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    foreach (rows[i]) rx(rows[i]);
    $display("test filter table done");
    for (int f = 0; f < 8; f++) begin
      @(posedge core_clk) nominal_phase_seg2_field <= 7'(f);
      repeat (2) @(posedge core_clk);
      #1;
      chk("seg2 length", f + 1, phase_seg2_tq_ff);
    end
    $display("test phase segment done");
    req(8'h02);
    repeat (20) @(posedge core_clk);
    dom_ifs3 <= 1'b1;
    @(posedge core_clk) dom_ifs3 <= 1'b0;
    wait_start();
    chk("start at ifs3", 1, pc_evt.ifs3);
    @(negedge core_clk);
    chk("first id bit", BUS_REC, tx_bit_ff);
    wait_done(1);
    chk("sent buffer", 1, done_q[0]);
    $display("test intermission start done");
    done_q.delete();
    req(8'h05);
    repeat (20) @(posedge core_clk);
    bus_free <= 1'b1;
    wait_done(2);
    chk("first sent", 0, done_q[0]);
    chk("second sent", 2, done_q[1]);
    chk("occurred", 8'h07, occ);
    chk("pending", 0, pend);
    chk("complete flag", 1, tcf);
    $display("test priority done");
    for (int r = 1; r < 3; r++) begin
      @(posedge core_clk) begin
        disable_auto_retx_ctl <= 1'b1;
        res_sel <= 2'(r);
      end
      req(8'h08);
      @(negedge core_clk);
      for (int k = 0; k < 200 && cfin[3] !== 1'b1; k++) @(negedge core_clk);
      @(negedge core_clk);
      chk("cancel finished", 8'h08, cfin);
      chk("pending", 0, pend);
    end
    $display("test no retransmit done");
    @(posedge core_clk) begin
      disable_auto_retx_ctl <= 1'b0;
      res_sel <= 2'h2;
    end
    done_q.delete();
    req(8'h08);
    wait_start();
    @(posedge core_clk) res_sel <= 2'h0;
    wait_done(1);
    chk("retried buffer", 3, done_q[0]);
    chk("cancel finished", 0, cfin);
    $display("test retransmit done");
    @(posedge core_clk) begin
      res_sel <= 2'h1;
      flag_clr <= 1'b1;
    end
    @(posedge core_clk) flag_clr <= 1'b0;
    done_q.delete();
    req(8'h30);
    wait_start();
    @(posedge core_clk) begin
      res_sel <= 2'h0;
      tx_add_request_reg <= 8'h01;
    end
    @(posedge core_clk) tx_add_request_reg <= '0;
    wait_done(3);
    foreach (done_q[i]) if (done_q[i] >= 3'h4) fq.push_back(done_q[i]);
    chk("fifo first", 4, fq[0]);
    chk("fifo second", 5, fq[1]);
    chk("fifo empty flag", 1, tfe);
    @(posedge core_clk) tqm <= TQM_QUEUE;
    req(8'h80);
    wait_done(4);
    chk("queue mode sent", 7, done_q[3]);
    $display("test fifo and queue mode done");
    end_sim();
  end
endmodule  // tb_top
